// File: common/iffe_pkg.sv
// Purpose: Shared constants for the frame field encoder
// Assumes: One 125 MHz clock, plain register port
// Notes: Field layout of the assembled frame, register map, CRC constants
package iffe_pkg;
  // ==========================================================
  // Frame layout
  localparam int FRAME_BYTES = 27;
  localparam int FRAME_W = FRAME_BYTES * 8;
  localparam int PAD_BYTES = (FRAME_BYTES % 4 == 0) ? 0 : 4 - (FRAME_BYTES % 4);
  localparam int CRC_BYTES = 4;
  localparam int STATUS_MSB = FRAME_W - 1;
  localparam int ACC_X_MSB = FRAME_W - 9;
  localparam int ACC_RAW_W = 26;
  localparam int ACC_W = 24;
  // ==========================================================
  // Status byte bits
  localparam int ST_SYSTEM = 7;
  localparam int ST_STARTING = 6;
  localparam int ST_ENV = 5;
  localparam int ST_ALL_AXES = 4;
  localparam int ST_OUT_ERR = 3;
  localparam logic [7:0] ST_ONLY_STARTING = 8'h40;
  // ==========================================================
  // Accelerometer range codes
  localparam logic [1:0] RANGE_10G = 2'h0;
  localparam logic [1:0] RANGE_30G = 2'h1;
  // ==========================================================
  // CRC
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED = 32'h0FFFFFFF;
  // ==========================================================
  // Registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_LAST_CRC = 8'h0C;
  localparam logic [7:0] REG_LAST_STATUS = 8'h10;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_RANGE_LSB = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_FRAME_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_STARTED = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
endpackage

// File: verilog/iffe_crc_rom.sv
// Purpose: CRC-32 byte lookup table with registered read
// Assumes: MSB-first, unreflected table
// Notes: Entries are generated from the polynomial, one cycle latency
`timescale 1ns/100ps
module iffe_crc_rom (
  // Clock
  input wire logic clk,
  // Lookup
  input wire logic [7:0] addr,
  output logic [31:0] q
);
  // ==========================================================
  // Table entry
  function automatic logic [31:0] entry(input logic [7:0] a);
    logic [31:0] r;
    r = {a, 24'h000000};
    for (int b = 0; b < 8; b++) begin
      r = r[31] ? ((r << 1) ^ iffe_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_ff @(posedge clk) begin
    q <= entry(addr);
  end

  rom_entry_one_a: assert property (@(posedge clk) (addr == 8'h01) |=>
    (q == iffe_pkg::CRC_POLY)) else $error("Table entry one wrong"); // RL16
endmodule // iffe_crc_rom

// File: verilog/iffe_encoder.sv
// Purpose: Assembles and streams the measurement fields of one frame
// Assumes: Field inputs and flags come from logic on clk
// Notes: Byte stream leaves on tx_data/tx_valid/tx_ready, CRC last
// Operation
// RL1: Accel scaled by range exponent 19/18/17
// RL2: Accel bytes sent high, middle, low
// RL3: Tilt 24-bit at 2^-22, high first
// RL4: Temperature 8.8 fixed point, upper first
// RL5: Delay microseconds 16-bit, high first
// RL6: CRC-32 preloaded with printed seed
// RL7: Live status only after startup completes
// RL8: Bit 7 system-wide abnormality
// RL9: Bit 6 set while starting
// RL10: Bit 5 abnormal external environment
// RL11: Bit 4 all axes out of condition
// RL12: Bit 3 three-axis output error
// RL13: Bits 2..0 Z, Y, X axis fault
// RL14: Sign in MSB of first byte
// RL15: All-zero status means normal
// RL16: Table-driven MSB-first unreflected CRC
// RL17: Zero-pad CRC input to four bytes
// RL18: Status sampled when frame assembled
// RL19: Receiver drops frames with bad CRC
`timescale 1ns/100ps
module iffe_encoder (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // Measurements
  input wire logic [iffe_pkg::ACC_RAW_W-1:0] accel_x,
  input wire logic [iffe_pkg::ACC_RAW_W-1:0] accel_y,
  input wire logic [iffe_pkg::ACC_RAW_W-1:0] accel_z,
  input wire logic [23:0] tilt_x,
  input wire logic [23:0] tilt_y,
  input wire logic [23:0] tilt_z,
  input wire logic [15:0] temp_x,
  input wire logic [15:0] temp_y,
  input wire logic [15:0] temp_z,
  input wire logic [15:0] delay_us,
  // Health flags
  input wire logic startup_done,
  input wire logic flag_system,
  input wire logic flag_env,
  input wire logic flag_all_axes,
  input wire logic flag_out_err,
  input wire logic [2:0] flag_axis,
  // Frame trigger and byte stream
  input wire logic frame_start,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic frame_busy
);
  localparam int FW = iffe_pkg::FRAME_W;

  typedef enum logic [2:0] {S_IDLE, S_SEND, S_HASH, S_PAD, S_CRC} iffe_state_t;

  iffe_state_t state;
  logic [FW-1:0] frame_q;
  logic [31:0] crc;
  logic [31:0] rom_q;
  logic [7:0] rom_addr;
  logic [4:0] idx;
  logic [1:0] pad_left;
  logic padding;
  logic [2:0] ctrl;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [31:0] last_crc;
  logic [7:0] last_status;
  logic started_q;
  logic [7:0] next_status;
  logic [FW-1:0] next_frame;
  logic [31:0] next_crc;
  logic [7:0] cur_byte;
  logic start_ok;
  logic tx_take;

  // ==========================================================
  // Field formatting
  function automatic logic [iffe_pkg::ACC_W-1:0] scale_acc(
    input logic [iffe_pkg::ACC_RAW_W-1:0] v, input logic [1:0] rng);
    logic signed [iffe_pkg::ACC_RAW_W-1:0] s;
    s = $signed(v);
    if (rng == iffe_pkg::RANGE_10G) begin
      s = s;
    end else if (rng == iffe_pkg::RANGE_30G) begin
      s = s >>> 1;
    end else begin
      s = s >>> 2;
    end
    if (s > $signed(26'h07FFFFF)) begin
      return 24'h7FFFFF;
    end else if (s < $signed(26'h3800000)) begin
      return 24'h800000;
    end
    return s[iffe_pkg::ACC_W-1:0];
  endfunction

  function automatic logic [7:0] byte_at(input logic [FW-1:0] f, input logic [4:0] i);
    return f[(FW - 8) - 8 * i +: 8];
  endfunction

  always_comb begin
    next_status = 8'h00;
    if (!startup_done) begin
      next_status = iffe_pkg::ST_ONLY_STARTING; // RL7 RL9
    end else begin
      next_status[iffe_pkg::ST_SYSTEM] = flag_system; // RL8
      next_status[iffe_pkg::ST_ENV] = flag_env; // RL10
      next_status[iffe_pkg::ST_ALL_AXES] = flag_all_axes; // RL11
      next_status[iffe_pkg::ST_OUT_ERR] = flag_out_err; // RL12
      next_status[2:0] = flag_axis; // RL13 RL15
    end
  end

  // Signed fields keep their sign in the top bit of the first byte
  assign next_frame = {next_status,
    scale_acc(accel_x, ctrl[2:1]), scale_acc(accel_y, ctrl[2:1]),
    scale_acc(accel_z, ctrl[2:1]), // RL1 RL2 RL14
    tilt_x, tilt_y, tilt_z, // RL3
    temp_x, temp_y, temp_z, // RL4
    delay_us}; // RL5

  // ==========================================================
  // CRC engine
  assign cur_byte = (state == S_PAD) ? 8'h00 : byte_at(frame_q, idx); // RL17
  assign rom_addr = crc[31:24] ^ cur_byte; // RL16
  assign next_crc = (crc << 8) ^ rom_q; // RL16

  iffe_crc_rom u_rom (
    .clk(clk),
    .addr(rom_addr),
    .q(rom_q)
  );

  // ==========================================================
  // Frame sequencer
  assign start_ok = frame_start && ctrl[iffe_pkg::CTRL_ENABLE];
  assign tx_take = tx_valid && tx_ready;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= S_IDLE;
      frame_q <= '0;
      crc <= 32'h00000000;
      idx <= 5'h00;
      pad_left <= 2'h0;
      padding <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      frame_busy <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_ok) begin
            frame_q <= next_frame; // RL18
            crc <= iffe_pkg::CRC_SEED; // RL6
            idx <= 5'h00;
            padding <= 1'b0;
            pad_left <= 2'(iffe_pkg::PAD_BYTES);
            tx_data <= byte_at(next_frame, 5'h00);
            tx_valid <= 1'b1;
            frame_busy <= 1'b1;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          if (tx_take) begin
            tx_valid <= 1'b0;
            state <= S_HASH;
          end
        end
        S_PAD: begin
          padding <= 1'b1;
          state <= S_HASH;
        end
        S_HASH: begin
          crc <= next_crc; // RL16
          if (padding) begin
            pad_left <= pad_left - 2'h1;
          end
          if (!padding && idx != 5'(iffe_pkg::FRAME_BYTES - 1)) begin
            idx <= idx + 5'h01;
            tx_data <= byte_at(frame_q, idx + 5'h01);
            tx_valid <= 1'b1;
            state <= S_SEND;
          end else if ((padding && pad_left > 2'h1) || (!padding && pad_left != 2'h0)) begin
            state <= S_PAD; // RL17
          end else begin
            idx <= 5'h00;
            tx_data <= next_crc[31:24];
            tx_valid <= 1'b1;
            state <= S_CRC;
          end
        end
        S_CRC: begin
          if (tx_take) begin
            idx <= idx + 5'h01;
            crc <= crc << 8;
            tx_data <= crc[23:16];
            if (idx == 5'(iffe_pkg::CRC_BYTES - 1)) begin
              tx_valid <= 1'b0;
              frame_busy <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers and interrupt
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl <= iffe_pkg::CTRL_RESET;
      irq_mask <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == iffe_pkg::REG_CTRL) begin
        ctrl <= reg_wdata[2:0];
      end
      if (reg_addr == iffe_pkg::REG_IRQ_MASK) begin
        irq_mask <= reg_wdata[iffe_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      last_crc <= 32'h00000000;
      last_status <= 8'h00;
      started_q <= 1'b0;
    end else begin
      started_q <= startup_done;
      if (state == S_IDLE && start_ok) begin
        last_status <= next_status;
      end
      if (state == S_HASH && padding && pad_left == 2'h1) begin
        last_crc <= next_crc;
      end else if (state == S_HASH && !padding && pad_left == 2'h0
                   && idx == 5'(iffe_pkg::FRAME_BYTES - 1)) begin
        last_crc <= next_crc;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= irq_stat
        & ~((reg_wr && reg_addr == iffe_pkg::REG_IRQ_STAT) ? reg_wdata[2:0] : 3'h0)
        | {startup_done && !started_q,
           state == S_IDLE && start_ok && next_status != 8'h00,
           state == S_CRC && tx_take && idx == 5'(iffe_pkg::CRC_BYTES - 1)};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      irq <= |(irq_stat & irq_mask);
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          iffe_pkg::REG_CTRL: reg_rdata <= {29'h0, ctrl};
          iffe_pkg::REG_IRQ_STAT: reg_rdata <= {29'h0, irq_stat};
          iffe_pkg::REG_IRQ_MASK: reg_rdata <= {29'h0, irq_mask};
          iffe_pkg::REG_LAST_CRC: reg_rdata <= last_crc;
          iffe_pkg::REG_LAST_STATUS: reg_rdata <= {24'h0, last_status};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  starting_status_a: assert property ((state == S_IDLE && start_ok && !startup_done) |=> // RL7
    frame_q[FW-1 -: 8] == iffe_pkg::ST_ONLY_STARTING) else $error("Status not masked");
  starting_bit_a: assert property ((state == S_IDLE && start_ok) |=> // RL9
    frame_q[iffe_pkg::STATUS_MSB-1] == !$past(startup_done)) else $error("Bit 6 wrong");
  fault_bits_a: assert property ((state == S_IDLE && start_ok && startup_done) |=> // RL8
    frame_q[FW-1 -: 8] == {$past(flag_system), 1'b0, $past(flag_env), $past(flag_all_axes),
    $past(flag_out_err), $past(flag_axis)}) else $error("Fault bits wrong");
  status_zero_a: assert property ((state == S_IDLE && start_ok && startup_done && !flag_system // RL15
    && !flag_env && !flag_all_axes && !flag_out_err && flag_axis == 3'h0) |=>
    frame_q[FW-1 -: 8] == 8'h00) else $error("Normal status not zero");
  accel_sign_a: assert property ((state == S_IDLE && start_ok) |=> // RL14
    frame_q[iffe_pkg::ACC_X_MSB] == $past(accel_x[iffe_pkg::ACC_RAW_W-1]))
    else $error("Accel sign lost");
  accel_range_a: assert property ((state == S_IDLE && start_ok && ctrl[2:1] == 2'h0 // RL1
    && accel_x[25:23] == 3'h0) |=> frame_q[iffe_pkg::ACC_X_MSB -: 24] == $past(accel_x[23:0]))
    else $error("10 g scaling wrong");
  byte_order_a: assert property ((state == S_SEND && tx_valid) |-> // RL2
    tx_data == byte_at(frame_q, idx)) else $error("Byte order wrong"); // RL3 RL4 RL5
  crc_seed_a: assert property ((state == S_IDLE && start_ok) |=> // RL6
    crc == iffe_pkg::CRC_SEED) else $error("CRC seed wrong");
  crc_step_a: assert property ((state == S_HASH) |=> // RL16
    crc == (($past(crc) << 8) ^ $past(rom_q))) else $error("CRC step wrong");
  pad_zero_a: assert property ((state == S_PAD) |-> rom_addr == crc[31:24]) // RL17
    else $error("Pad byte not zero");
  stall_hold_a: assert property ((tx_valid && !tx_ready) |=> // RL2
    tx_valid && $stable(tx_data)) else $error("Byte dropped under stall");

  frame_done_c: cover property (state == S_CRC && tx_take
    && idx == 5'(iffe_pkg::CRC_BYTES - 1));
  range_50_c: cover property (state == S_IDLE && start_ok && ctrl[2:1] == 2'h2);
  fault_frame_c: cover property (state == S_IDLE && start_ok && startup_done && flag_system);
endmodule // iffe_encoder

// File: testbench/iffe_tb_crc.svh
// Purpose: Byte-wise CRC of a frame for the bench and the host model
// Assumes: MSB-first table walk, seed and polynomial from the package
// Notes: Pads a copy of the bytes with zeros to a multiple of four
`ifndef IFFE_TB_CRC_SVH
`define IFFE_TB_CRC_SVH
function automatic logic [31:0] iffe_crc(input logic [7:0] b [$]);
  logic [31:0] r;
  logic [31:0] t;
  r = iffe_pkg::CRC_SEED;
  while (b.size() % 4 != 0) b.push_back(8'h00);
  foreach (b[i]) begin
    t = {r[31:24] ^ b[i], 24'h000000};
    repeat (8) t = t[31] ? (t << 1) ^ iffe_pkg::CRC_POLY : t << 1;
    r = (r << 8) ^ t;
  end
  return r;
endfunction
`endif

// File: testbench/iffe_host_model.sv
// Purpose: Host receiver that takes frame bytes and checks their CRC
// Assumes: Frames are the data bytes followed by four CRC bytes
// Notes: Stalls the stream at random
`timescale 1ns/100ps
module iffe_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Byte stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Frame results
  output int good_frames,
  output int bad_frames
);
  `include "iffe_tb_crc.svh"
  // ==========================================================
  // Receive and check
  logic [7:0] rx [$];
  logic [31:0] sent;
  always @(posedge clk) begin
    tx_ready <= reset_n && ($urandom_range(3) != 0);
    if (!reset_n) begin
      rx.delete();
      good_frames <= 0;
      bad_frames <= 0;
    end else if (tx_valid && tx_ready) begin
      rx.push_back(tx_data);
      if (rx.size() == iffe_pkg::FRAME_BYTES + iffe_pkg::CRC_BYTES) begin
        sent = {rx[27], rx[28], rx[29], rx[30]};
        if (iffe_crc(rx[0:iffe_pkg::FRAME_BYTES-1]) == sent) good_frames <= good_frames + 1;
        else bad_frames <= bad_frames + 1;
        rx.delete();
      end
    end
  end
endmodule // iffe_host_model

// File: testbench/iffe_encoder_bench.sv
// Purpose: Self-checking bench of the frame field encoder
// Assumes: Host model on the byte stream, plain register port
// Notes: Expected bytes and read data are queued, monitors compare
`timescale 1ns/100ps
module iffe_encoder_bench;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic [25:0] acc [3] = '{default: 26'h0000000};
  logic [23:0] tilt [3] = '{default: 24'h000000};
  logic [15:0] temp [3] = '{default: 16'h0000};
  logic [15:0] delay_us = 16'h0000;
  logic startup_done = 1'b0;
  logic flag_system = 1'b0, flag_env = 1'b0, flag_all_axes = 1'b0, flag_out_err = 1'b0;
  logic [2:0] flag_axis = 3'h0;
  logic frame_start = 1'b0;
  logic [7:0] tx_data;
  logic tx_valid, tx_ready, frame_busy, rd_d = 1'b0;
  int good_frames, bad_frames, err_count = 0, samples_checked = 0, cycles = 0;
  logic [7:0] exp_b [$];
  logic [31:0] exp_r [$];
  logic [31:0] last_crc;
  always #4 clk = ~clk;
  iffe_encoder i_iffe_encoder (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .accel_x(acc[0]), .accel_y(acc[1]), .accel_z(acc[2]), .tilt_x(tilt[0]), .tilt_y(tilt[1]),
    .tilt_z(tilt[2]), .temp_x(temp[0]), .temp_y(temp[1]), .temp_z(temp[2]), .delay_us(delay_us),
    .startup_done(startup_done), .flag_system(flag_system), .flag_env(flag_env),
    .flag_all_axes(flag_all_axes), .flag_out_err(flag_out_err), .flag_axis(flag_axis),
    .frame_start(frame_start), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .frame_busy(frame_busy));
  iffe_host_model i_iffe_host_model (.clk(clk), .reset_n(reset_n), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .good_frames(good_frames), .bad_frames(bad_frames));
  // ==========================================================
  // Compare and report
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected byte at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Monitors
  always @(posedge clk) if (tx_valid === 1'b1 && tx_ready === 1'b1)
    cmp_byte(tx_data, exp_b.pop_front());
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (rd_d) cmp_word(reg_rdata, exp_r.pop_front());
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // ==========================================================
  // Drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_r.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_idle(input logic [31:0] e);
    @(negedge clk);
    cmp_word({31'h00000000, irq}, e);
    @(posedge clk);
  endtask
  task automatic rnd;
    for (int i = 0; i < 3; i++) begin
      acc[i] <= (i == 0 && !startup_done) ? 26'(24'($urandom) >> 1)
        : $urandom_range(1) ? 26'($urandom) : 26'($signed(24'($urandom)));
      tilt[i] <= 24'($urandom);
      temp[i] <= 16'($urandom);
    end
    delay_us <= 16'($urandom);
    {flag_system, flag_env, flag_all_axes, flag_out_err, flag_axis} <= 7'($urandom);
  endtask
  task automatic frame(input logic [1:0] rng);
    logic [7:0] q [$];
    logic signed [25:0] s;
    logic [23:0] a;
    logic [7:0] st;
    wr(iffe_pkg::REG_CTRL, {29'h00000000, rng, 1'b1});
    st = startup_done ? {flag_system, 1'b0, flag_env, flag_all_axes, flag_out_err, flag_axis}
      : 8'h40;
    q = {st};
    for (int i = 0; i < 3; i++) begin
      s = $signed(acc[i]) >>> (rng == 2'h0 ? 0 : rng == 2'h1 ? 1 : 2);
      a = s > 26'sh07FFFFF ? 24'h7FFFFF : s < -26'sh0800000 ? 24'h800000 : s[23:0];
      q = {q, a[23:16], a[15:8], a[7:0]};
    end
    for (int i = 0; i < 3; i++) q = {q, tilt[i][23:16], tilt[i][15:8], tilt[i][7:0]};
    for (int i = 0; i < 3; i++) q = {q, temp[i][15:8], temp[i][7:0]};
    q = {q, delay_us[15:8], delay_us[7:0]};
    last_crc = i_iffe_host_model.iffe_crc(q);
    exp_b = {exp_b, q, last_crc[31:24], last_crc[23:16], last_crc[15:8], last_crc[7:0]};
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    for (int n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (frame_busy === 1'b0) break;
    end
    @(posedge clk);
    rd(iffe_pkg::REG_LAST_STATUS, {24'h000000, st});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(30));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(iffe_pkg::REG_CTRL, 32'h00000001);
    rd(8'h14, 32'h00000000);
    rnd();
    frame(iffe_pkg::RANGE_10G);
    startup_done <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rnd();
      frame(2'(i));
    end
    {flag_system, flag_env, flag_all_axes, flag_out_err, flag_axis} <= 7'h00;
    frame(iffe_pkg::RANGE_30G);
    rd(iffe_pkg::REG_LAST_CRC, last_crc);
    chk_idle(32'h00000000);
    rd(iffe_pkg::REG_IRQ_STAT, 32'h00000007);
    wr(iffe_pkg::REG_IRQ_MASK, 32'h00000001);
    rd(iffe_pkg::REG_IRQ_MASK, 32'h00000001);
    chk_idle(32'h00000001);
    wr(iffe_pkg::REG_IRQ_STAT, 32'h00000001);
    chk_idle(32'h00000000);
    rd(iffe_pkg::REG_IRQ_STAT, 32'h00000006);
    wr(iffe_pkg::REG_CTRL, 32'h00000000);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_word({31'h00000000, frame_busy}, 32'h00000000);
    cmp_word(32'(exp_b.size()), 32'h00000000);
    cmp_word(32'(good_frames), 32'h0000000A);
    cmp_word(32'(bad_frames), 32'h00000000);
    end_sim();
  end
endmodule // iffe_encoder_bench
